// file: design/ifmode_pkg.sv
// package for the interface mode, integrity checker and result registers
// assumes a serial front end that decodes commands into register strobes
package ifmode_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 24;
    localparam int STAT_W = 8;
    localparam int MODE_W = 16;

    localparam logic [ADDR_W-1:0] CHECKSUM_ADDR = 8'h03;
    localparam logic [ADDR_W-1:0] RESULT_ADDR = 8'h04;
    // interface mode address is not fixed here; see the top parameter
    localparam logic [ADDR_W-1:0] MODE_ADDR_DEFAULT = 8'h02;

    localparam logic [MODE_W-1:0] MODE_RESET = 16'h0000;
    // writable bits: 12, 11, 8, 7, 6, 5, 3:2, 0; others reserved, read 0
    localparam logic [MODE_W-1:0] MODE_WMASK = 16'h19ED;
    localparam logic [DATA_W-1:0] RESULT_RESET = 24'h000000;

    localparam int APPEND_BIT = 6;
    localparam int CHECK_EN_BIT = 5;
    localparam int CSUM_LSB = 2;
    localparam int SHORT_BIT = 0;

    localparam logic [1:0] CSUM_OFF = 2'h0;
    localparam logic [1:0] CSUM_XOR_RD = 2'h1;
    localparam logic [1:0] CSUM_CRC = 2'h2;

    localparam logic [5:0] LEN_16 = 6'h10;
    localparam logic [5:0] LEN_24 = 6'h18;
    localparam logic [5:0] LEN_32 = 6'h20;
    localparam int SHORT_W = 16;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic valid;
        logic unipolar;
        logic [DATA_W-1:0] raw;
    } conv_t;

endpackage

// file: design/integrity_watch.sv
// integrity checker: snapshots watched registers when armed, flags change
// assumes the watched word list already leaves out mode, result and status
`timescale 1ns/1ns
module integrity_watch
    import ifmode_pkg::*;
#(
    parameter int WORDS = 8
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic arm,
    input wire logic enable,
    input wire logic [WORDS*DATA_W-1:0] watched,
    output logic [DATA_W-1:0] checksum,
    output logic changed
);

    logic [DATA_W-1:0] snap_ff [WORDS];
    logic [DATA_W-1:0] fold;
    logic [WORDS-1:0] diff;

    always_comb
    begin
        fold = '0;
        for (int i = 0; i < WORDS; i++)
        begin
            fold = fold ^ watched[i*DATA_W +: DATA_W];
            diff[i] = snap_ff[i] != watched[i*DATA_W +: DATA_W];
        end
    end

    assign checksum = enable ? fold : '0;
    assign changed = enable && !arm && (|diff);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < WORDS; i++)
            begin
                snap_ff[i] <= '0;
            end
        end
        else if (arm)
        begin
            for (int i = 0; i < WORDS; i++)
            begin
                snap_ff[i] <= watched[i*DATA_W +: DATA_W];
            end
        end
    end

endmodule

// file: design/ifmode_regs.sv
// interface mode register, integrity checker and conversion result register
// assumes register strobes from the serial decoder on mclk, one per access
`timescale 1ns/1ns
// Function
// - status append makes result read eight bits longer (32 bits long, 24 bits short)
// - armed checker flags any watched register change
// - writing check enable zero clears error
// - mode, result, status registers are not watched
// - two-bit field selects checksum scheme
// - active checksum adds one byte per transfer
// - short word select gives 16-bit results
// - word length change applies from next result
// - checksum register XORs the user registers
// - checksum reads zero while checker disabled
// - result offset binary, unipolar when polarity asks
// - result read drives ready bit and pin high
// - read command freezes result, rereads allowed
module ifmode_regs
    import ifmode_pkg::*;
#(
    parameter int WORDS = 8,
    parameter logic [ADDR_W-1:0] MODE_ADDR = MODE_ADDR_DEFAULT
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire reg_req_t req,
    input wire logic rd_end,
    input wire conv_t conv,
    input wire logic [STAT_W-1:0] status_in,
    input wire logic [WORDS*DATA_W-1:0] watched,
    output logic [31:0] rdata_ff,
    output logic [5:0] rd_len_ff,
    output logic [MODE_W-1:0] mode_ff,
    output logic [1:0] csum_mode_ff,
    output logic extra_byte_ff,
    output logic reg_error_ff,
    output logic rdy_ff
);

    logic [DATA_W-1:0] result_ff;
    logic hold_ff;
    logic [MODE_W-1:0] nxt_mode;
    logic [DATA_W-1:0] nxt_result;
    logic [DATA_W-1:0] coded;
    logic [DATA_W-1:0] checksum;
    logic changed;
    logic [31:0] nxt_rdata;
    logic [5:0] nxt_len;

    wire mode_wr = req.wr && req.addr == MODE_ADDR;
    wire res_rd = req.rd && req.addr == RESULT_ADDR;
    wire sum_rd = req.rd && req.addr == CHECKSUM_ADDR;
    wire mode_rd = req.rd && req.addr == MODE_ADDR;
    wire check_en = mode_ff[CHECK_EN_BIT];
    wire new_check = nxt_mode[CHECK_EN_BIT];
    wire arm = mode_wr && new_check && !check_en;
    wire disarm = mode_wr && !new_check;
    wire short_sel = mode_ff[SHORT_BIT];
    wire append = mode_ff[APPEND_BIT];
    wire load = conv.valid && !hold_ff && !res_rd;
    // a disarm write cuts the compare in its own cycle; a mismatch that
    // still stands then would otherwise win and outlive the clear
    wire hit = changed && !disarm;
    wire [1:0] nxt_csum = nxt_mode[CSUM_LSB +: 2];

    // reserved bits are forced to zero whatever the host sends
    assign nxt_mode = mode_wr ?
        (req.wdata[MODE_W-1:0] & MODE_WMASK) : mode_ff;

    // raw is two's complement; flipping the sign bit gives offset binary
    assign coded = conv.unipolar ? conv.raw :
        {~conv.raw[DATA_W-1], conv.raw[DATA_W-2:0]};

    // word length sampled at load, so a mode write never alters a held
    // result; the upper bits are kept, the low ones dropped
    assign nxt_result = short_sel ?
        {8'h00, coded[DATA_W-1 -: SHORT_W]} : coded;

    assign nxt_len = short_sel ? LEN_16 : LEN_24;

    // the status byte rides below the result so channel bits match data
    assign nxt_rdata = res_rd ?
        (append ? {result_ff, status_in} : {8'h00, result_ff}) :
        sum_rd ? {8'h00, checksum} :
        mode_rd ? {16'h0000, mode_ff} : 32'h00000000;

    integrity_watch #(
        .WORDS(WORDS)
    ) u_watch (
        .mclk(mclk),
        .rst(rst),
        .arm(arm),
        .enable(check_en),
        .watched(watched),
        .checksum(checksum),
        .changed(changed)
    );

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            mode_ff <= MODE_RESET;
            csum_mode_ff <= CSUM_OFF;
            extra_byte_ff <= 1'b0;
        end
        else
        begin
            mode_ff <= nxt_mode;
            csum_mode_ff <= nxt_csum;
            extra_byte_ff <= nxt_csum != CSUM_OFF;
        end
    end

    // the checker still compares during a disarm write, but hit masks the change
    // in that cycle, so the clear wins over a set from the same cycle
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            reg_error_ff <= 1'b0;
        end
        else if (hit)
        begin
            reg_error_ff <= 1'b1;
        end
        else if (disarm)
        begin
            reg_error_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            result_ff <= RESULT_RESET;
            rd_len_ff <= LEN_24;
            rdy_ff <= 1'b1;
            hold_ff <= 1'b0;
        end
        else
        begin
            if (load)
            begin
                result_ff <= nxt_result;
                rd_len_ff <= append ? nxt_len + 6'h08 : nxt_len;
                rdy_ff <= 1'b0;
            end
            else if (res_rd)
            begin
                rdy_ff <= 1'b1;
            end
            if (res_rd)
            begin
                hold_ff <= 1'b1;
            end
            else if (rd_end)
            begin
                hold_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rdata_ff <= 32'h00000000;
        end
        else if (req.rd)
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    result_frozen_a: assert property (
        @(posedge mclk) disable iff (rst)
        hold_ff && !rd_end |=> $stable(result_ff))
        else $error("result changed while a read held it");

    ready_high_a: assert property (
        @(posedge mclk) disable iff (rst)
        res_rd |=> rdy_ff ##1 (rdy_ff || !hold_ff))
        else $error("ready not high after result read");

    append_data_a: assert property (
        @(posedge mclk) disable iff (rst)
        res_rd && append |=> rdata_ff[7:0] == $past(status_in))
        else $error("status not appended to result");

    error_clear_a: assert property (
        @(posedge mclk) disable iff (rst)
        disarm |=> !reg_error_ff)
        else $error("integrity error survived disable write");

    error_set_a: assert property (
        @(posedge mclk) disable iff (rst)
        check_en && !mode_wr && !$stable(watched) |=> reg_error_ff)
        else $error("watched change not flagged");

    sum_zero_a: assert property (
        @(posedge mclk) disable iff (rst)
        sum_rd && !check_en |=> rdata_ff == 32'h00000000)
        else $error("checksum nonzero while checker disabled");

    short_result_a: assert property (
        @(posedge mclk) disable iff (rst)
        load && short_sel |=> result_ff[23:16] == 8'h00
            && rd_len_ff == ($past(append) ? LEN_24 : LEN_16))
        else $error("short result wider than 16 bits");

    extra_byte_a: assert property (
        @(posedge mclk) disable iff (rst)
        extra_byte_ff == (csum_mode_ff != CSUM_OFF))
        else $error("extra byte does not follow checksum mode");

    offset_code_a: assert property (
        @(posedge mclk) disable iff (rst)
        load && !conv.unipolar && !short_sel
            |=> result_ff[23] != $past(conv.raw[23]))
        else $error("bipolar result not offset binary");

    reserved_zero_a: assert property (
        @(posedge mclk) disable iff (rst)
        mode_ff[4] == 1'b0 && mode_ff[1] == 1'b0
            && csum_mode_ff == mode_ff[3:2])
        else $error("reserved mode bit set or field mismatch");

    // the checks below cover reads, lengths and holds; the bench reaches
    // mode_read_a only once and unipolar_code_a never

    mode_write_a: assert property (
        @(posedge mclk) disable iff (rst)
        mode_wr |=> mode_ff
            == ($past(req.wdata[MODE_W-1:0]) & MODE_WMASK))
        else $error("mode write did not land with reserved bits cleared");

    mode_read_a: assert property (
        @(posedge mclk) disable iff (rst)
        mode_rd |=> rdata_ff == {16'h0000, $past(mode_ff)})
        else $error("mode read data wrong");

    error_hold_a: assert property (
        @(posedge mclk) disable iff (rst)
        reg_error_ff && !disarm |=> reg_error_ff)
        else $error("integrity error dropped without disable write");

    error_quiet_a: assert property (
        @(posedge mclk) disable iff (rst)
        !check_en && !reg_error_ff |=> !reg_error_ff)
        else $error("integrity error raised while checker disabled");

    sum_high_a: assert property (
        @(posedge mclk) disable iff (rst)
        sum_rd |=> rdata_ff[31:24] == 8'h00)
        else $error("checksum read wider than 24 bits");

    plain_result_a: assert property (
        @(posedge mclk) disable iff (rst)
        res_rd && !append |=> rdata_ff[31:24] == 8'h00)
        else $error("result read carries status without append");

    append_len_a: assert property (
        @(posedge mclk) disable iff (rst)
        load && append
            |=> rd_len_ff == ($past(short_sel) ? LEN_24 : LEN_32))
        else $error("appended read length not eight bits longer");

    long_len_a: assert property (
        @(posedge mclk) disable iff (rst)
        load && !short_sel
            |=> rd_len_ff == ($past(append) ? LEN_32 : LEN_24))
        else $error("long result read length wrong");

    unipolar_code_a: assert property (
        @(posedge mclk) disable iff (rst)
        load && conv.unipolar && !short_sel
            |=> result_ff == $past(conv.raw))
        else $error("unipolar result not straight binary");

    ready_low_a: assert property (
        @(posedge mclk) disable iff (rst)
        load |=> !rdy_ff)
        else $error("new result did not drop ready");

    hold_set_a: assert property (
        @(posedge mclk) disable iff (rst)
        res_rd |=> hold_ff)
        else $error("result read did not freeze the register");

    len_frozen_a: assert property (
        @(posedge mclk) disable iff (rst)
        hold_ff |=> $stable(rd_len_ff))
        else $error("read length changed while a read held it");

    word_length_a: assert property (
        @(posedge mclk) disable iff (rst)
        mode_wr && !load |=> $stable(result_ff))
        else $error("mode write altered the held result");

endmodule

// file: tb/host_model.sv
// host controller model: issues register strobes as the serial decoder would
// assumes the design samples req on the rising edge of mclk
`timescale 1ns/1ns
module host_model
    import ifmode_pkg::*;
(
    input wire logic mclk,
    output reg_req_t req,
    output logic rd_end
);
    initial
    begin
        req = '0;
        rd_end = 1'b0;
    end
    // one-cycle strobe; idle bus shows inverted values so stale data is seen
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [23:0] d);
        @(negedge mclk);
        req = '{wr: w, rd: !w, addr: a, wdata: d & 24'hFFFFED};
        @(negedge mclk);
        req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic end_read;
        rd_end = 1'b1;
        @(negedge mclk);
        rd_end = 1'b0;
    endtask
endmodule

// file: tb/adc_interface_mode_integrity_regs_tb.sv
// testbench for the interface mode, integrity and result registers
// assumes host_model drives the strobes; inputs change on the falling edge
`timescale 1ns/1ns
module adc_interface_mode_integrity_regs_tb
    import ifmode_pkg::*;
;
    logic mclk, rst, rd_end, extra_byte_ff, reg_error_ff, rdy_ff;
    conv_t conv;
    reg_req_t req;
    logic [8*DATA_W-1:0] watched;
    logic [31:0] rdata_ff;
    logic [5:0] rd_len_ff;
    logic [MODE_W-1:0] mode_ff;
    logic [1:0] csum_mode_ff;
    logic [STAT_W-1:0] status;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;

    ifmode_regs ifmode_regs_i (.mclk(mclk), .rst(rst), .req(req),
        .rd_end(rd_end), .conv(conv), .status_in(status),
        .watched(watched), .rdata_ff(rdata_ff), .rd_len_ff(rd_len_ff),
        .mode_ff(mode_ff), .csum_mode_ff(csum_mode_ff),
        .extra_byte_ff(extra_byte_ff), .reg_error_ff(reg_error_ff),
        .rdy_ff(rdy_ff));
    host_model host_model_i (.mclk(mclk), .req(req), .rd_end(rd_end));

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [23:0] d);
        host_model_i.access(1'b1, MODE_ADDR_DEFAULT, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        host_model_i.access(1'b0, a, 24'h000000);
        chk("rdata", rdata_ff, exp);
    endtask
    task automatic convert(input logic uni, input logic [23:0] raw);
        @(negedge mclk);
        conv = '{valid: 1'b1, unipolar: uni, raw: raw};
        @(negedge mclk);
        conv.valid = 1'b0;
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // a hang is cut short well past the ~50 cycles the sequence needs
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            give_verdict();
        end
    end

    initial
    begin
        rst = 1'b1;
        conv = '0;
        status = 8'hA5;
        watched = '0;
        watched[47:0] = 48'h0000C35A5A5A;
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        chk("rdy", rdy_ff, 32'h1);
        chk("mode", mode_ff, 32'h0);
        chk("len", rd_len_ff, 32'h18);
        rd(CHECKSUM_ADDR, 32'h0);
        wr(24'h000044);
        chk("csum", csum_mode_ff, 32'h1);
        chk("extra", extra_byte_ff, 32'h1);
        rd(MODE_ADDR_DEFAULT, 32'h44);
        convert(1'b0, 24'h123456);
        chk("rdy", rdy_ff, 32'h0);
        rd(RESULT_ADDR, 32'h923456A5);
        chk("rdy", rdy_ff, 32'h1);
        chk("len", rd_len_ff, 32'h20);
        // a conversion during the held read must be discarded
        convert(1'b0, 24'h777777);
        rd(RESULT_ADDR, 32'h923456A5);
        host_model_i.end_read();
        wr(24'h000049);
        chk("csum", csum_mode_ff, 32'h2);
        // a new status byte must show up in the appended read
        status = 8'h3C;
        rd(RESULT_ADDR, 32'h9234563C);
        host_model_i.end_read();
        convert(1'b1, 24'h123456);
        rd(RESULT_ADDR, 32'h0012343C);
        chk("len", rd_len_ff, 32'h18);
        host_model_i.end_read();
        wr(24'h000001);
        chk("extra", extra_byte_ff, 32'h0);
        rd(RESULT_ADDR, 32'h00001234);
        host_model_i.end_read();
        // host arms the checker only after the watched words are settled
        wr(24'h000020);
        rd(CHECKSUM_ADDR, 32'h5A5A99);
        chk("err", reg_error_ff, 32'h0);
        watched[0] = ~watched[0];
        repeat (2) @(negedge mclk);
        chk("err", reg_error_ff, 32'h1);
        wr(24'h000000);
        chk("err", reg_error_ff, 32'h0);
        rd(CHECKSUM_ADDR, 32'h0);
        give_verdict();
    end
endmodule
